/* File: design/lp_handshake_regs.vh */
`ifndef LP_HANDSHAKE_REGS_VH
`define LP_HANDSHAKE_REGS_VH

// reset values of the handshake outputs: a domain leaves reset running
`define LP_ACK_RESET 1'h1
`define LP_ACTIVE_RESET 1'h1
// request level seen by the synchroniser while in reset (no idle request)
`define LP_REQ_RESET 1'h1
// synchronised domain reset level while the block itself is in reset
`define LP_DOMRST_N_RESET 1'h0
// one-hot state codes of the per-domain handshake
`define LP_ST_RUN 4'h1
`define LP_ST_DRAIN 4'h2
`define LP_ST_IDLE 4'h4
`define LP_ST_WAKE 4'h8
// default width of the outstanding transaction counter
`define LP_CNT_W_DEFAULT 8

`endif

/* File: design/domain_lp_handshake.v */
`timescale 1ns/1ps
`include "lp_handshake_regs.vh"

module domain_lp_handshake (
	input wire mclk,
	input wire sys_rst,
	input wire dom_rst_n,
	input wire csysreq,
	output wire req_sync,
	output wire dom_live
);

	reg req_meta_reg;
	reg req_sync_reg;
	reg rst_meta_reg;
	reg rst_sync_reg;

	// both pins come from outside this clock: two flops, only the second is read
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			req_meta_reg <= `LP_REQ_RESET;
			req_sync_reg <= `LP_REQ_RESET;
			rst_meta_reg <= `LP_DOMRST_N_RESET;
			rst_sync_reg <= `LP_DOMRST_N_RESET;
		end
		else
		begin
			req_meta_reg <= csysreq;
			req_sync_reg <= req_meta_reg;
			rst_meta_reg <= dom_rst_n;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// a domain reset takes two edges to bite and two to let go
	assign req_sync = req_sync_reg;
	assign dom_live = rst_sync_reg;

endmodule // domain_lp_handshake

/* File: design/lp_domain_handshakes.v */
`timescale 1ns/1ps
`include "lp_handshake_regs.vh"

module lp_domain_handshakes #(
	parameter NUM_FILTERS = 2,
	parameter CNT_W = `LP_CNT_W_DEFAULT
) (
	input wire mclk,
	input wire sys_rst,
	input wire [NUM_FILTERS-1:0] filt_rst_n,
	input wire [NUM_FILTERS-1:0] filt_csysreq,
	input wire [NUM_FILTERS-1:0] filt_txn_start,
	input wire [NUM_FILTERS-1:0] filt_txn_done,
	input wire [NUM_FILTERS-1:0] filt_wake_want,
	output wire [NUM_FILTERS-1:0] filt_txn_stall,
	output wire [NUM_FILTERS-1:0] filt_csysack,
	output wire [NUM_FILTERS-1:0] filt_cactive,
	input wire ctl_rst_n,
	input wire ctl_csysreq,
	input wire ctl_txn_start,
	input wire ctl_txn_done,
	input wire ctl_wake_want,
	output wire ctl_txn_stall,
	output wire ctl_csysack,
	output wire ctl_cactive
);

	// control unit sits one index above the filter domains
	localparam NUM_DOM = NUM_FILTERS + 1;
	localparam [3:0] ST_RUN = `LP_ST_RUN;
	localparam [3:0] ST_DRAIN = `LP_ST_DRAIN;
	localparam [3:0] ST_IDLE = `LP_ST_IDLE;
	localparam [3:0] ST_WAKE = `LP_ST_WAKE;
	localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'h0}};
	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'h0}}, 1'h1};

	// one bit per domain, so every handshake runs the same logic
	wire [NUM_DOM-1:0] dom_rst_n;
	wire [NUM_DOM-1:0] dom_req;
	wire [NUM_DOM-1:0] dom_start;
	wire [NUM_DOM-1:0] dom_done;
	wire [NUM_DOM-1:0] dom_wake;
	wire [NUM_DOM-1:0] dom_stall;
	wire [NUM_DOM-1:0] dom_ack;
	wire [NUM_DOM-1:0] dom_active;

	// gather the pins; the control unit is just one more domain here
	assign dom_rst_n = {ctl_rst_n, filt_rst_n};
	assign dom_req = {ctl_csysreq, filt_csysreq};
	assign dom_start = {ctl_txn_start, filt_txn_start};
	assign dom_done = {ctl_txn_done, filt_txn_done};
	assign dom_wake = {ctl_wake_want, filt_wake_want};

	// hand the answers back to the per-domain pins
	assign filt_txn_stall = dom_stall[NUM_FILTERS-1:0];
	assign filt_csysack = dom_ack[NUM_FILTERS-1:0];
	assign filt_cactive = dom_active[NUM_FILTERS-1:0];
	assign ctl_txn_stall = dom_stall[NUM_FILTERS];
	assign ctl_csysack = dom_ack[NUM_FILTERS];
	assign ctl_cactive = dom_active[NUM_FILTERS];

	// next handshake state; a pending idle request never turns back to run
	function [3:0] next_state;
		input [3:0] cur;
		input req_high;
		input drained;
		begin
			case (cur)
				ST_RUN:
					next_state = req_high ? ST_RUN : ST_DRAIN;
				ST_DRAIN:
					next_state = drained ? ST_IDLE : ST_DRAIN;
				ST_IDLE:
					next_state = req_high ? ST_WAKE : ST_IDLE;
				ST_WAKE:
					next_state = ST_RUN;
				default:
					next_state = ST_RUN;
			endcase
		end
	endfunction

	// outstanding count; wraps past its top, so CNT_W must cover the deepest load
	function [CNT_W-1:0] count_step;
		input [CNT_W-1:0] count;
		input up;
		input down;
		begin
			count_step = count;
			if (up && !down)
				count_step = count + CNT_ONE;
			else if (!up && down && count != CNT_ZERO)
				count_step = count - CNT_ONE;
		end
	endfunction

	// one handshake per domain; binds the controller, not this logic
	genvar g;
	generate
		for (g = 0; g < NUM_DOM; g = g + 1)
		begin : dom_hs
			wire req_sync;
			wire dom_live;
			wire accept;
			wire drained;
			reg [3:0] state_reg;
			reg [3:0] state_next;
			reg [CNT_W-1:0] cnt_reg;
			reg [CNT_W-1:0] cnt_next;
			reg ack_reg;
			reg ack_next;
			reg active_reg;
			reg active_next;

			// request and domain reset are pins, so they are synchronised first
			domain_lp_handshake domain_lp_handshake_inst (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.dom_rst_n(dom_rst_n[g]),
				.csysreq(dom_req[g]),
				.req_sync(req_sync),
				.dom_live(dom_live)
			);

			// new work only taken while running: stalled before the ack drops
			assign dom_stall[g] = (state_reg != ST_RUN);
			assign accept = dom_start[g] & ~dom_stall[g];
			assign drained = (cnt_reg == CNT_ZERO);
			assign dom_ack[g] = ack_reg;
			assign dom_active[g] = active_reg;

			// accepted starts minus completions; a done at zero is ignored
			always @*
			begin
				cnt_next = count_step(cnt_reg, accept, dom_done[g]);
			end

			// idle needs an empty count as well as the request
			always @*
			begin
				state_next = next_state(state_reg, req_sync, drained);
			end

			// ack falls only once drained and rises on wake, so it follows the request
			always @*
			begin
				ack_next = ack_reg;
				if (state_next == ST_IDLE)
					ack_next = 1'h0;
				else if (state_next == ST_WAKE)
					ack_next = 1'h1;
			end

			// idle drops clock-active unless pending work wants the domain back
			always @*
			begin
				if (state_next == ST_IDLE)
					active_next = dom_wake[g];
				else
					active_next = 1'h1;
			end

			// a domain reset forces running: the domain leaves reset needing its clock
			always @(posedge mclk)
			begin
				if (sys_rst || !dom_live)
				begin
					state_reg <= ST_RUN;
				end
				else
				begin
					state_reg <= state_next;
				end
			end

			// work in flight is lost with the domain reset, so the count restarts
			always @(posedge mclk)
			begin
				if (sys_rst || !dom_live)
				begin
					cnt_reg <= CNT_ZERO;
				end
				else
				begin
					cnt_reg <= cnt_next;
				end
			end

			// ack straight from a flop, free of decode glitches
			always @(posedge mclk)
			begin
				if (sys_rst || !dom_live)
				begin
					ack_reg <= `LP_ACK_RESET;
				end
				else
				begin
					ack_reg <= ack_next;
				end
			end

			// clock-active straight from a flop as well
			always @(posedge mclk)
			begin
				if (sys_rst || !dom_live)
				begin
					active_reg <= `LP_ACTIVE_RESET;
				end
				else
				begin
					active_reg <= active_next;
				end
			end
		end
	endgenerate

endmodule // lp_domain_handshakes

/* File: verif/lp_ctrl_model.sv */
`timescale 1ns/1ps
module lp_ctrl_model (
	input wire mclk,
	input wire go_idle,
	input wire csysack,
	output reg csysreq,
	output wire clk_off
);
initial csysreq = 1'h1;
// request moves only once the ack has followed it
always @(posedge mclk)
	if (csysack == csysreq)
		csysreq <= #1 !go_idle;
// gate from the finished handshake, never from clock-active
assign clk_off = !csysreq && !csysack;
endmodule // lp_ctrl_model

/* File: verif/lp_hs_props.sv */
`timescale 1ns/1ps
module lp_hs_props (
	input wire mclk,
	input wire sys_rst,
	input wire ctl_rst_n,
	input wire ctl_csysreq,
	input wire ctl_wake_want,
	input wire ctl_txn_stall,
	input wire ctl_csysack,
	input wire ctl_cactive
);
default clocking @(posedge mclk); endclocking
default disable iff (sys_rst);
// the sync flops make every answer a few edges late
sequence idle_ask; $fell(ctl_csysreq); endsequence
sequence wake_ask; $rose(ctl_csysreq); endsequence
ack_fall_idle_a: assert property ($fell(ctl_csysack) |-> !ctl_csysreq && $past(ctl_txn_stall))
	else $error("ack fell without drain");
no_refuse_a: assert property (idle_ask |-> ##[2:5] ctl_txn_stall)
	else $error("idle request not taken");
wake_ack_a: assert property (wake_ask |-> ##[2:5] ctl_csysack)
	else $error("no ack after resume");
active_run_a: assert property (ctl_csysack |-> ctl_cactive)
	else $error("clock-active low while running");
idle_active_a: assert property (!ctl_csysack && !$past(ctl_csysack)
	|-> ctl_cactive == $past(ctl_wake_want))
	else $error("idle clock-active wrong");
steady_eq_a: assert property (ctl_csysreq [*8] |-> ctl_csysack)
	else $error("ack not equal to request");
stall_run_a: assert property (!ctl_txn_stall |-> ctl_csysack)
	else $error("work allowed while idle");
dom_reset_a: assert property (!ctl_rst_n [*5] |-> ctl_csysack && !ctl_txn_stall)
	else $error("domain reset ignored");
endmodule // lp_hs_props
bind lp_domain_handshakes lp_hs_props lp_hs_props_inst (.mclk, .sys_rst, .ctl_rst_n,
	.ctl_csysreq, .ctl_wake_want, .ctl_txn_stall, .ctl_csysack, .ctl_cactive);

/* File: verif/lp_domain_handshakes_tb_top.sv */
`timescale 1ns/1ps
module lp_domain_handshakes_tb_top;
reg mclk = 0;
reg sys_rst = 1;
reg [2:0] go_idle = 0, start = 0, done = 0, ww = 0, rst_n = 3'h7;
wire [2:0] req, ack, act, stall, off;
integer seed = 60099, bad_count = 0, cmp_count = 0, i, n, cnt [0:2];
always #4 mclk = ~mclk;
// bit 2 is the control unit, bits 1:0 the filter domains
lp_ctrl_model lp_ctrl_model_inst [2:0] (.mclk(mclk), .go_idle(go_idle), .csysack(ack),
	.csysreq(req), .clk_off(off));
lp_domain_handshakes lp_domain_handshakes_inst (.mclk(mclk), .sys_rst(sys_rst),
	.filt_rst_n(rst_n[1:0]), .filt_csysreq(req[1:0]), .filt_txn_start(start[1:0]),
	.filt_txn_done(done[1:0]), .filt_wake_want(ww[1:0]), .filt_txn_stall(stall[1:0]),
	.filt_csysack(ack[1:0]), .filt_cactive(act[1:0]), .ctl_rst_n(rst_n[2]),
	.ctl_csysreq(req[2]), .ctl_txn_start(start[2]), .ctl_txn_done(done[2]),
	.ctl_wake_want(ww[2]), .ctl_txn_stall(stall[2]), .ctl_csysack(ack[2]),
	.ctl_cactive(act[2]));
function [2:0] busy;
	input dummy;
	for (i = 0; i < 3; i = i + 1)
		busy[i] = cnt[i] > 0;
endfunction
task step(input integer k);
	begin
		repeat (k) @(posedge mclk);
		#1;
	end
endtask
task chk(input [2:0] s, input [2:0] e);
	begin
		cmp_count = cmp_count + 1;
		if (s !== e)
		begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED t=%0t seen %b exp %b", $time, s, e);
		end
	end
endtask
task test_done;
	begin
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
endtask
// a hung handshake must not stall the run
initial
begin
	#200000;
	bad_count = bad_count + 1;
	test_done;
end
// random work, idle with some outstanding, drain, resume
initial
begin
	step(16);
	sys_rst = 0;
	step(3);
	for (n = 0; n < 8; n = n + 1)
	begin
		for (i = 0; i < 3; i = i + 1)
			cnt[i] = 0;
		repeat (3)
		begin
			start = $random(seed);
			for (i = 0; i < 3; i = i + 1)
				cnt[i] = cnt[i] + start[i];
			step(1);
			start = 0;
			step(1);
		end
		go_idle = 3'h7;
		ww = $random(seed);
		step(6);
		chk(ack, busy(0));
		while (busy(0) != 0)
		begin
			done = busy(0);
			for (i = 0; i < 3; i = i + 1)
				cnt[i] = cnt[i] - done[i];
			step(1);
			done = 0;
			step(1);
		end
		step(3);
		chk(ack, 3'h0);
		chk(stall, 3'h7);
		chk(act, ww);
		chk(off, 3'h7);
		// work offered while idle must not be counted; next round would hang
		start = $random(seed);
		step(1);
		start = 0;
		go_idle = 0;
		step(6);
		chk(ack, 3'h7);
		chk(stall, 3'h0);
		chk(act, 3'h7);
		chk(off, 3'h0);
		$display("test %0d finished", n);
	end
	// domain reset taken while idle returns it to running
	go_idle = 3'h7;
	step(8);
	rst_n = 0;
	step(6);
	chk(ack, 3'h7);
	chk(stall, 3'h0);
	rst_n = 3'h7;
	step(8);
	chk(ack, 3'h0);
	$display("test domain reset finished");
	test_done;
end
endmodule // lp_domain_handshakes_tb_top
